// ==== src/odsc_pkg.sv ====
package odsc_pkg;

   // Channel and word geometry
   localparam int NUM_CH = 8;
   localparam int CODE_W = 12;
   localparam int WORD_W = 16;
   localparam int CH_W = 3;
   localparam logic [4:0] FRAME_LAST = 5'h0f;

   // Field positions in a serial word
   localparam int TYPE_BIT = 15;
   localparam int ADDR_HI = 14;
   localparam int ADDR_LO = 12;
   localparam int DATA_HI = 11;
   localparam int FUNC_HI = 14;
   localparam int FUNC_LO = 13;
   localparam int RST_CTRL_BIT = 12;
   localparam int SUPPLY_LO = 0;
   localparam int BUF_LO = 2;
   localparam int GAIN_LO = 4;
   localparam int LDMODE_LO = 0;
   localparam int PWRDN_LO = 0;

   // Control functions
   localparam logic [1:0] FN_REFGAIN = 2'h0;
   localparam logic [1:0] FN_LOAD = 2'h1;
   localparam logic [1:0] FN_PWRDN = 2'h2;
   localparam logic [1:0] FN_RESET = 2'h3;

   typedef enum logic [1:0] {
      ODSC_LD_CONT = 2'b00,
      ODSC_LD_LATCH = 2'b01,
      ODSC_LD_SINGLE = 2'b10,
      ODSC_LD_RSVD = 2'b11
   } odsc_ldmode_t;

   typedef enum logic [1:0] {
      ODSC_FS_IDLE = 2'b00,
      ODSC_FS_SHIFT = 2'b01,
      ODSC_FS_FULL = 2'b10
   } odsc_frame_t;

   // Wake-up delay after leaving power-down, least time rounded up
   localparam int CLK_NS = 20;
   localparam int WAKE_NS = 2500;
   localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
   localparam int WAKE_W = 8;
   localparam logic [WAKE_W-1:0] WAKE_CNT = WAKE_W'(WAKE_CYC);

   // Register map, byte addresses
   localparam int ADDR_W = 8;
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_CMD = 8'h04;
   localparam logic [7:0] REG_FRAMES = 8'h08;
   localparam logic [2:0] REG_INPUT_PAGE = 3'h1;
   localparam logic [2:0] REG_DAC_PAGE = 3'h2;

   // Status register fields
   localparam int ST_SUPPLY_LO = 0;
   localparam int ST_BUF_LO = 2;
   localparam int ST_GAIN_LO = 4;
   localparam int ST_LDMODE_LO = 6;
   localparam int ST_PWRDN_LO = 8;
   localparam int ST_OUTEN_LO = 16;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== src/odsc_top.sv ====
`timescale 1ns/100ps
`default_nettype none

// Function
// [R1] Shift one data bit per serial clock falling edge, sixteen edges per frame.
// [R2] Serial clock and data count only while frame select is low.
// [R3] Host raises frame select only after the sixteenth falling edge.
// [R4] A complete frame loads the addressed input register or runs its control function.
// [R5] Frame select rising early discards the word; no register changes.
// [R6] Words arrive MSB first; bit 15 picks data write or control.
// [R7] Bits 14..12 address channels A through H in ascending binary.
// [R8] Data starts at bit 11; narrower variants ignore their low bits.
// [R9] Host sends zeros in data bits the fitted variant ignores.
// [R10] Channel codes are straight binary, zero to full scale.
// [R11] Control bits 14..13 pick reference/gain, load mode, power-down or reset.
// [R12] Bits 2 and 3 select buffered reference for quads A-D and E-H.
// [R13] Bits 4 and 5 select doubled gain for quads A-D and E-H.
// [R14] Bits 0 and 1 select supply as reference for each quad.
// [R15] Supply reference forces unbuffered and unity gain for that quad.
// [R16] After reset: all channels on, unbuffered, unity gain, latched load mode.
// [R17] After reset all input and output codes are zero until written.
// [R18] Powered-down channels keep codes and still accept new data.
// [R19] A powered-down channel's output is disabled (high impedance).
// [R20] Leaving power-down, output re-enables after the wake-up delay.
// [R21] Load mode bits 1..0: continuous, latched, single transfer, reserved.
// [R22] Power-down word bits 7..0 power down channels H..A when set.
// [R23] Reset word clears codes; bit 12 set also restores control defaults.
// [R24] Undefined control bits have no effect.
module odsc_top #(
   parameter int RES_BITS = 12
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Serial link pins, asynchronous to aclk
   input wire logic sclk,
   input wire logic sync_n,
   input wire logic din,
   input wire logic load_outputs_n,
   // Converter control outputs
   output var logic [odsc_pkg::NUM_CH*odsc_pkg::CODE_W-1:0] dac_code,
   output var logic [odsc_pkg::NUM_CH-1:0] out_enable,
   output var logic [1:0] ref_buffered,
   output var logic [1:0] gain_double,
   output var logic [1:0] ref_supply,
   // AXI4-Lite write address
   input wire logic [odsc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output var logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output var logic s_axi_wready,
   // AXI4-Lite write response
   output var logic [1:0] s_axi_bresp,
   output var logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [odsc_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output var logic s_axi_arready,
   // AXI4-Lite read data
   output var logic [31:0] s_axi_rdata,
   output var logic [1:0] s_axi_rresp,
   output var logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int NCH = odsc_pkg::NUM_CH;
   localparam int CW = odsc_pkg::CODE_W;
   // Low bits beyond the fitted resolution are dropped
   localparam logic [CW-1:0] DATA_MASK = CW'({CW{1'b1}} << (CW - RES_BITS));
   typedef struct packed {
      // Pin synchronisers: _m first stage, _s second, _p history
      logic sclk_m;
      logic sclk_s;
      logic sclk_p;
      logic sync_m;
      logic sync_s;
      logic din_m;
      logic din_s;
      logic ldn_m;
      logic ldn_s;
      // Serial framing
      odsc_pkg::odsc_frame_t frame;
      logic [4:0] bit_cnt;
      logic [odsc_pkg::WORD_W-1:0] shreg;
      // Channel codes
      logic [NCH-1:0][CW-1:0] in_reg;
      logic [NCH-1:0][CW-1:0] dac_reg;
      logic [NCH-1:0] dirty;
      // Control settings
      logic [1:0] supply_sel;
      logic [1:0] buf_sel;
      logic [1:0] gain_sel;
      odsc_pkg::odsc_ldmode_t ldmode;
      logic xfer_once;
      logic [NCH-1:0] pwrdn;
      logic [NCH-1:0][odsc_pkg::WAKE_W-1:0] wake;
      logic [NCH-1:0] out_en;
      logic [1:0] obuf;
      logic [1:0] ogain;
      // Bookkeeping
      logic [odsc_pkg::WORD_W-1:0] last_word;
      logic [15:0] good_cnt;
      logic [15:0] abort_cnt;
      logic [odsc_pkg::WORD_W-1:0] sw_word;
      logic sw_pend;
      // Bus slave
      logic awready;
      logic wready;
      logic aw_held;
      logic w_held;
      logic [odsc_pkg::ADDR_W-1:0] aw_addr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } odsc_state_t;
   odsc_state_t st_r;
   odsc_state_t st_nxt;
   // Runs one complete 16-bit word against the state
   function automatic odsc_state_t exec_word(input odsc_state_t s, input logic [15:0] w);
      odsc_state_t r;
      logic [odsc_pkg::CH_W-1:0] ch;
      r = s;
      ch = w[odsc_pkg::ADDR_HI:odsc_pkg::ADDR_LO]; // [R7]
      if (!w[odsc_pkg::TYPE_BIT]) begin // [R6]
         r.in_reg[ch] = w[odsc_pkg::DATA_HI -: CW] & DATA_MASK; // [R8] [R10]
         r.dirty[ch] = 1'b1;
      end else begin
         case (w[odsc_pkg::FUNC_HI:odsc_pkg::FUNC_LO]) // [R11]
            odsc_pkg::FN_REFGAIN: begin
               r.supply_sel = w[odsc_pkg::SUPPLY_LO +: 2]; // [R14]
               r.buf_sel = w[odsc_pkg::BUF_LO +: 2]; // [R12]
               r.gain_sel = w[odsc_pkg::GAIN_LO +: 2]; // [R13]
            end
            odsc_pkg::FN_LOAD: begin
               // Reserved code leaves the mode as it was
               if (w[odsc_pkg::LDMODE_LO +: 2] != odsc_pkg::ODSC_LD_RSVD) begin // [R21]
                  r.ldmode = odsc_pkg::odsc_ldmode_t'(w[odsc_pkg::LDMODE_LO +: 2]);
                  r.xfer_once = (w[odsc_pkg::LDMODE_LO +: 2] == odsc_pkg::ODSC_LD_SINGLE);
               end
            end
            odsc_pkg::FN_PWRDN: begin
               r.pwrdn = w[odsc_pkg::PWRDN_LO +: NCH]; // [R22]
            end
            odsc_pkg::FN_RESET: begin
               r.in_reg = '0; // [R23]
               r.dac_reg = '0;
               r.dirty = '0;
               if (w[odsc_pkg::RST_CTRL_BIT]) begin
                  r.supply_sel = 2'h0;
                  r.buf_sel = 2'h0;
                  r.gain_sel = 2'h0;
                  r.ldmode = odsc_pkg::ODSC_LD_LATCH;
                  r.xfer_once = 1'b0;
                  r.pwrdn = '0;
               end
            end
            default: begin
            end
         endcase
         // Other bit positions are never looked at [R24]
      end
      r.last_word = w;
      return r;
   endfunction
   // Read mux; unmapped offsets answer SLVERR with zero data
   function automatic logic [33:0] read_reg(input odsc_state_t s, input logic [7:0] a);
      logic [31:0] d;
      logic [1:0] resp;
      d = 32'h0000_0000;
      resp = odsc_pkg::RESP_OKAY;
      if (a == odsc_pkg::REG_STATUS) begin
         d[odsc_pkg::ST_SUPPLY_LO +: 2] = s.supply_sel;
         d[odsc_pkg::ST_BUF_LO +: 2] = s.buf_sel;
         d[odsc_pkg::ST_GAIN_LO +: 2] = s.gain_sel;
         d[odsc_pkg::ST_LDMODE_LO +: 2] = s.ldmode;
         d[odsc_pkg::ST_PWRDN_LO +: NCH] = s.pwrdn;
         d[odsc_pkg::ST_OUTEN_LO +: NCH] = s.out_en;
      end else if (a == odsc_pkg::REG_CMD) begin
         d[15:0] = s.last_word;
      end else if (a == odsc_pkg::REG_FRAMES) begin
         d = {s.abort_cnt, s.good_cnt};
      end else if (a[7:5] == odsc_pkg::REG_INPUT_PAGE && a[1:0] == 2'h0) begin
         d[CW-1:0] = s.in_reg[a[4:2]];
      end else if (a[7:5] == odsc_pkg::REG_DAC_PAGE && a[1:0] == 2'h0) begin
         d[CW-1:0] = s.dac_reg[a[4:2]];
      end else begin
         resp = odsc_pkg::RESP_SLVERR;
      end
      return {resp, d};
   endfunction
   always_comb begin
      odsc_state_t n;
      logic sclk_fall;
      logic word_done;
      logic xfer;
      logic [33:0] rd;
      n = st_r;
      word_done = 1'b0;
      rd = 34'h0_0000_0000;
      xfer = 1'b0;
      sclk_fall = st_r.sclk_p & ~st_r.sclk_s;
      // Two flops on every pin before any logic
      n.sclk_m = sclk;
      n.sclk_s = st_r.sclk_m;
      n.sclk_p = st_r.sclk_s;
      n.sync_m = sync_n;
      n.sync_s = st_r.sync_m;
      n.din_m = din;
      n.din_s = st_r.din_m;
      n.ldn_m = load_outputs_n;
      n.ldn_s = st_r.ldn_m;
      // Bus write channels, taken in either order
      if (s_axi_awvalid && st_r.awready) begin
         n.awready = 1'b0;
         n.aw_held = 1'b1;
         n.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_r.wready) begin
         n.wready = 1'b0;
         n.w_held = 1'b1;
         n.wdata = s_axi_wdata;
         n.wstrb = s_axi_wstrb;
      end
      if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
         n.aw_held = 1'b0;
         n.w_held = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = odsc_pkg::RESP_OKAY;
         if (st_r.aw_addr == odsc_pkg::REG_CMD && st_r.wstrb[1:0] == 2'h3) begin
            n.sw_word = st_r.wdata[15:0];
            n.sw_pend = 1'b1;
         end else if (st_r.aw_addr == odsc_pkg::REG_FRAMES) begin
            // Cleared before this cycle's frame event is counted
            n.good_cnt = 16'h0000;
            n.abort_cnt = 16'h0000;
         end else begin
            n.bresp = odsc_pkg::RESP_SLVERR;
         end
      end
      if (st_r.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
         n.awready = 1'b1;
         n.wready = 1'b1;
      end
      // Bus read
      if (s_axi_arvalid && st_r.arready) begin
         rd = read_reg(st_r, s_axi_araddr);
         n.arready = 1'b0;
         n.rvalid = 1'b1;
         n.rdata = rd[31:0];
         n.rresp = rd[33:32];
      end
      if (st_r.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
         n.arready = 1'b1;
      end
      // Serial framing
      case (st_r.frame)
         odsc_pkg::ODSC_FS_IDLE: begin
            if (!st_r.sync_s) begin // [R2]
               n.frame = odsc_pkg::ODSC_FS_SHIFT;
               n.bit_cnt = 5'h00;
            end
         end
         odsc_pkg::ODSC_FS_SHIFT: begin
            if (st_r.sync_s) begin
               // Partial word dropped; only the abort count is bumped
               n.frame = odsc_pkg::ODSC_FS_IDLE; // [R5]
               n.abort_cnt = n.abort_cnt + 16'h0001;
            end else if (sclk_fall) begin
               n.shreg = {st_r.shreg[odsc_pkg::WORD_W-2:0], st_r.din_s}; // [R1] [R6]
               n.bit_cnt = st_r.bit_cnt + 5'h01;
               if (st_r.bit_cnt == odsc_pkg::FRAME_LAST) begin
                  n.frame = odsc_pkg::ODSC_FS_FULL;
               end
            end
         end
         odsc_pkg::ODSC_FS_FULL: begin
            // Extra clock edges after the sixteenth are ignored
            if (st_r.sync_s) begin
               n.frame = odsc_pkg::ODSC_FS_IDLE;
               word_done = 1'b1; // [R4]
               n.good_cnt = n.good_cnt + 16'h0001;
            end
         end
         default: begin
            n.frame = odsc_pkg::ODSC_FS_IDLE;
         end
      endcase
      // Serial word wins; a bus command waits one cycle behind it
      if (word_done) begin
         n = exec_word(n, st_r.shreg);
      end else if (st_r.sw_pend) begin
         n = exec_word(n, st_r.sw_word);
         n.sw_pend = 1'b0;
      end
      // Output-code transfer; only channels written since the last one
      xfer = (n.ldmode == odsc_pkg::ODSC_LD_CONT) || !st_r.ldn_s || n.xfer_once; // [R21]
      if (xfer) begin
         for (int i = 0; i < NCH; i++) begin
            if (n.dirty[i]) begin
               n.dac_reg[i] = n.in_reg[i]; // [R18]
               n.dirty[i] = 1'b0;
            end
         end
         n.xfer_once = 1'b0;
      end
      // Output enable with wake-up delay
      for (int i = 0; i < NCH; i++) begin
         if (n.pwrdn[i]) begin
            n.out_en[i] = 1'b0; // [R19]
            n.wake[i] = odsc_pkg::WAKE_CNT;
         end else if (st_r.wake[i] != '0) begin
            n.wake[i] = st_r.wake[i] - odsc_pkg::WAKE_W'(1); // [R20]
            n.out_en[i] = (st_r.wake[i] == odsc_pkg::WAKE_W'(1));
         end else begin
            n.out_en[i] = 1'b1;
         end
      end
      // Supply reference overrides buffer and gain
      n.obuf = n.buf_sel & ~n.supply_sel; // [R15]
      n.ogain = n.gain_sel & ~n.supply_sel; // [R15]
      st_nxt = n;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0; // [R17]
         st_r.sync_m <= 1'b1;
         st_r.sync_s <= 1'b1;
         st_r.ldn_m <= 1'b1;
         st_r.ldn_s <= 1'b1;
         st_r.frame <= odsc_pkg::ODSC_FS_IDLE;
         st_r.ldmode <= odsc_pkg::ODSC_LD_LATCH; // [R16]
         st_r.out_en <= {NCH{1'b1}}; // [R16]
         st_r.awready <= 1'b1;
         st_r.wready <= 1'b1;
         st_r.arready <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign dac_code = st_r.dac_reg;
   assign out_enable = st_r.out_en;
   assign ref_buffered = st_r.obuf;
   assign gain_double = st_r.ogain;
   assign ref_supply = st_r.supply_sel;
   assign s_axi_awready = st_r.awready;
   assign s_axi_wready = st_r.wready;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_arready = st_r.arready;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;
endmodule

`default_nettype wire

// ==== verification/odsc_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module odsc_host_model (
   // Serial pins
   output var logic sclk,
   output var logic sync_n,
   output var logic din
);
   initial begin
      sclk = 1'b1;
      sync_n = 1'b1;
      din = 1'b0;
   end
   // Clock parked high outside frames, so stray edges never reach the shifter
   // Steps land on aclk edges; non-blocking keeps the sampling order fixed
   task automatic send(input logic [15:0] w, input int n);
      sync_n <= 1'b0;
      for (int i = 15; i > 15 - n; i--) begin
         din <= w[i];
         #80 sclk <= 1'b0;
         #80 sclk <= 1'b1;
      end
      #80 sync_n <= 1'b1;
      // Released line flips so a stale bit cannot pass as data
      din <= ~din;
      #200;
   endtask
endmodule
`default_nettype wire

// ==== verification/odsc_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module odsc_checker (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Converter outputs
   input wire logic [95:0] dac_code,
   input wire logic [7:0] out_enable,
   input wire logic [1:0] ref_buffered,
   input wire logic [1:0] gain_double,
   input wire logic [1:0] ref_supply,
   // Bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [15:0] low_cnt_r;
   always_ff @(posedge aclk) begin
      if (!aresetn || out_enable[0]) low_cnt_r <= 16'h0000;
      else if (low_cnt_r != 16'hffff) low_cnt_r <= low_cnt_r + 16'h0001;
   end
   chk_reset_state: assert property ($rose(aresetn) |-> dac_code == 96'h0 && out_enable == 8'hff
      && ref_supply == 2'h0 && ref_buffered == 2'h0 && gain_double == 2'h0) else $error("bad reset state");
   chk_supply_unbuf: assert property ((ref_supply & ref_buffered) == 2'h0) else $error("buffer with supply");
   chk_supply_unity: assert property ((ref_supply & gain_double) == 2'h0) else $error("gain with supply");
   chk_wake_delay: assert property ($rose(out_enable[0]) |-> low_cnt_r >= 16'(odsc_pkg::WAKE_CYC))
      else $error("wake too early");
   // Both held flags register first, so the response is two edges behind the handshake
   chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("late write response");
   chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   chk_ready_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("ready during response");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   chk_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'hfc
      |=> s_axi_rresp == odsc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
   cov_power_down: cover property ($fell(out_enable[0]));
   cov_supply_ref: cover property ($rose(ref_supply[1]));
   cov_read_error: cover property (s_axi_rvalid && s_axi_rresp == odsc_pkg::RESP_SLVERR);
endmodule
`default_nettype wire

// ==== verification/tb_octal_dac_serial_control.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_octal_dac_serial_control;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic load_outputs_n = 1'b1;
   logic sclk, sync_n, din;
   logic [95:0] dac_code;
   logic [7:0] out_enable;
   logic [1:0] ref_buffered, gain_double, ref_supply, s_axi_bresp, s_axi_rresp, r;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [11:0] codes [8];
   logic [5:0] v;
   int miscompares = 0, num_checks = 0;
   odsc_top #(.RES_BITS(12)) dut (
      .aclk, .aresetn, .sclk, .sync_n, .din, .load_outputs_n, .dac_code, .out_enable,
      .ref_buffered, .gain_double, .ref_supply, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready
   );
   odsc_host_model host (.sclk, .sync_n, .din);
   always #10 aclk = ~aclk;
   task automatic results;
      if (miscompares == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] w, input logic [3:0] s);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= w;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bready && s_axi_bvalid === 1'b1) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            return;
         end
         // Late ready exercises the held response
         if (s_axi_bvalid === 1'b1) s_axi_bready <= 1'b1;
      end
   endtask
   task automatic axi_rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rready && s_axi_rvalid === 1'b1) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            return;
         end
         if (s_axi_rvalid === 1'b1) s_axi_rready <= 1'b1;
      end
   endtask
   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      axi_rd(a);
      chk(what, d, exp);
   endtask
   task automatic sw(input logic [15:0] w);
      host.send(w, 16);
      repeat (2) @(posedge aclk);
   endtask
   function automatic logic [31:0] dac(input int ch);
      return 32'(dac_code[ch*12 +: 12]);
   endfunction
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      rchk("status", 8'h00, 32'h00ff0040);
      for (int ch = 0; ch < 8; ch++) begin
         chk("code", dac(ch), 32'h0);
         // Full-width variant fitted, so every data bit is meaningful
         codes[ch] = (ch == 7) ? 12'hfff : 12'(ch * 12'h123 + 1);
         sw({1'b0, 3'(ch), codes[ch]});
      end
      for (int ch = 0; ch < 8; ch++) begin
         rchk("input", 8'h20 + 8'(4 * ch), 32'(codes[ch]));
         chk("held", dac(ch), 32'h0);
      end
      load_outputs_n <= 1'b0;
      repeat (8) @(posedge aclk);
      load_outputs_n <= 1'b1;
      repeat (6) @(posedge aclk);
      for (int ch = 0; ch < 8; ch++) chk("out", dac(ch), 32'(codes[ch]));
      host.send(16'h0555, 15);
      rchk("abort", 8'h20, 32'(codes[0]));
      rchk("frames", 8'h08, 32'h00010008);
      for (int i = 0; i < 2; i++) begin
         v = i ? 6'h36 : 6'h3c;
         if (i == 0) sw(16'h9fc0 | 16'(v));
         else axi_wr(8'h04, 32'(16'h9fc0 | 16'(v)), 4'hf);
         repeat (4) @(posedge aclk);
         chk("supply", 32'(ref_supply), 32'(v[1:0]));
         chk("buf", 32'(ref_buffered), 32'(v[3:2] & ~v[1:0]));
         chk("gain", 32'(gain_double), 32'(v[5:4] & ~v[1:0]));
      end
      rchk("last", 8'h04, 32'h00009ff6);
      sw(16'ha000);
      axi_rd(8'h00);
      chk("mode", 32'(d[7:6]), 32'h0);
      sw(16'h20a5);
      chk("cont", dac(2), 32'h0a5);
      sw(16'ha003);
      axi_rd(8'h00);
      chk("rsvd", 32'(d[7:6]), 32'h0);
      sw(16'ha001);
      sw(16'h15a0);
      chk("latch", dac(1), 32'h124);
      sw(16'ha002);
      chk("single", dac(1), 32'h5a0);
      sw(16'hc081);
      chk("pd", 32'(out_enable), 32'h7e);
      axi_rd(8'h00);
      chk("pdst", 32'(d[23:8]), 32'h7e81);
      sw(16'h0777);
      rchk("pdin", 8'h20, 32'h777);
      sw(16'hc000);
      repeat (100) @(posedge aclk);
      chk("waking", 32'(out_enable), 32'h7e);
      repeat (30) @(posedge aclk);
      chk("awake", 32'(out_enable), 32'hff);
      sw(16'he000);
      for (int ch = 0; ch < 8; ch++) begin
         chk("clr", dac(ch), 32'h0);
         rchk("clrin", 8'h20 + 8'(4 * ch), 32'h0);
      end
      chk("keep", 32'(ref_supply), 32'h2);
      sw(16'hf000);
      rchk("defaults", 8'h00, 32'h00ff0040);
      axi_wr(8'hfc, 32'h0, 4'hf);
      chk("bresp", 32'(r), 32'(odsc_pkg::RESP_SLVERR));
      // Half-strobed command must not run as a power-down of every channel
      axi_wr(8'h04, 32'h0000c0ff, 4'h1);
      chk("strb", 32'(r), 32'(odsc_pkg::RESP_SLVERR));
      chk("noop", 32'(out_enable), 32'hff);
      axi_rd(8'hfc);
      chk("rresp", 32'(r), 32'(odsc_pkg::RESP_SLVERR));
      chk("rdata", d, 32'h0);
      axi_wr(8'h08, 32'h0, 4'hf);
      rchk("cleared", 8'h08, 32'h0);
      results();
   end
   initial begin
      #500000;
      miscompares++;
      results();
   end
endmodule
bind odsc_top odsc_checker chk_i (
   .aclk, .aresetn, .dac_code, .out_enable, .ref_buffered, .gain_double, .ref_supply,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire
